/* logic/iob_pkg.sv */
// Shared constants and types for the I/O bus interrupt dialogue
//==============================================================
// Operation
// - Data path 36 bits, bit 00 most significant
// - Seven select lines pick one wired controller
// - Function codes 000..011 name data transfers
// - Controller decodes on demand, answers transfer/acknowledge
// - Acknowledge keeps bus adapter out; timeout otherwise
// - Controller asserts transfer when ready to execute
// - Low select lines carry served channel number
// - High select lines carry chosen controller number
// - Function 4: interrupters place physical number
// - Function 5: matching controller knows it is selected
// - Selected controller drives special word on data
// - First requester wins bus; interrupts await release
// - Return demand takes bus back from interrupts
// - Channel 0 always sampled; others need enables
// - Conditions-out write loads all channel enables
// - Lowest pending channel number wins priority
// - Test request holds until grant; ring then frozen
// - Grant drives channel, high function bit, starts timer
// - Grant sets translator to inbound direction
// - Demand T2/T5/T6; T3 latch numbers; T4 low bit
// - T5 holds count until transfer seen or forced
// - T6 held until interrupt-cycle flag sets
// - Demand drops first; complete clears grant and lines
package iob_pkg;
  localparam int IOB_DATA_W = 36;
  localparam int IOB_SEL_W = 7;
  localparam int IOB_FN_W = 3;
  localparam int IOB_CHANS = 8;
  typedef logic [0:IOB_DATA_W-1] iob_word_t; // Index 0 is the MSB
  // Function codes, leftmost bit is the function high bit
  localparam logic [2:0] IOB_FN_CONDITIONS_OUT = 3'h0;
  localparam logic [2:0] IOB_FN_CONDITIONS_IN = 3'h1;
  localparam logic [2:0] IOB_FN_DATA_OUT = 3'h2;
  localparam logic [2:0] IOB_FN_DATA_IN = 3'h3;
  localparam logic [2:0] IOB_FN_SERVED = 3'h4;
  localparam logic [2:0] IOB_FN_VECTOR = 3'h5;
  // Timing
  localparam int IOB_CLK_NS = 10;
  localparam int IOB_TSTATE_NS = 50;
  localparam int IOB_TSTATE_CYC = (IOB_TSTATE_NS + IOB_CLK_NS - 1) / IOB_CLK_NS;
  localparam int IOB_TRANSFER_STROBE_TMO_NS = 1000;
  localparam int IOB_TRANSFER_STROBE_TMO_CYC = IOB_TRANSFER_STROBE_TMO_NS / IOB_CLK_NS;
  localparam int IOB_CNT_W = 8;
  localparam logic [IOB_CNT_W-1:0] IOB_CNT_RST = 8'h00;
  typedef enum logic [3:0] {
    IOB_TS_IDLE = 4'h0,
    IOB_TS_T2 = 4'h2,
    IOB_TS_T3 = 4'h3,
    IOB_TS_T4 = 4'h4,
    IOB_TS_T5 = 4'h5,
    IOB_TS_T6 = 4'h6,
    IOB_TS_T7 = 4'h7,
    IOB_TS_COMP = 4'h8
  } iob_tstate_t;
  typedef enum logic [2:0] {
    IOB_RC_LOAD = 3'h0,
    IOB_RC_WAIT1 = 3'h1,
    IOB_RC_WAIT2 = 3'h2,
    IOB_RC_TEST = 3'h3,
    IOB_RC_FROZEN = 3'h4
  } iob_ring_t;
  typedef enum logic [1:0] {
    IOB_OWN_NONE = 2'h0,
    IOB_OWN_EU = 2'h1,
    IOB_OWN_INT = 2'h2
  } iob_owner_t;
  // Lowest-numbered set line of a 16-line group, line 0 being the leftmost bit
  // Lines are numbered from the left, so scanning upward keeps the leftmost hit
  function automatic logic [3:0] iob_lowest(input logic [15:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (v[i]) begin
        r = 4'(15 - i);
      end
    end
    return r;
  endfunction : iob_lowest
endpackage : iob_pkg

/* logic/iob_bus_if.sv */
// Parallel I/O bus joining the processor end and a controller end
`timescale 1ns/1ps
`default_nettype none
interface iob_bus_if;
  import iob_pkg::*;
  iob_word_t proc_data;
  logic proc_data_oe;
  iob_word_t ctl_data;
  logic ctl_data_oe;
  iob_word_t data;
  logic [6:0] cs; // cs[6] is select line 00
  logic [2:0] fn; // fn[2] is function high bit
  logic demand;
  logic ack;
  logic transfer_strobe;
  logic [0:7] int_req;
  // Shared data wire level worked out from both enables
  assign data = proc_data_oe ? proc_data : (ctl_data_oe ? ctl_data : '0);
  modport proc (output proc_data, proc_data_oe, cs, fn, demand,
                input data, ack, transfer_strobe, int_req);
  modport ctl (output ctl_data, ctl_data_oe, ack, transfer_strobe, int_req,
               input data, cs, fn, demand);
endinterface : iob_bus_if
`default_nettype wire

/* logic/iob_ctl.sv */
// Peripheral controller end of the I/O bus
`timescale 1ns/1ps
`default_nettype none
module iob_ctl #(
  parameter logic [6:0] SELECT_CODE = 7'h01,
  parameter logic [3:0] PHYS_NUM = 4'h1,
  parameter logic [2:0] CHANNEL = 3'h1
) (
  input wire logic sys_clk_in, // System clock
  input wire logic rst_in, // Async reset, active high
  iob_bus_if.ctl bus, // I/O bus
  input wire logic int_req_in, // Interrupt wanted, level
  input wire iob_pkg::iob_word_t vector_in, // Special word for service
  input wire iob_pkg::iob_word_t cond_in_in, // Conditions read value
  input wire iob_pkg::iob_word_t data_in_in, // Data read value
  output iob_pkg::iob_word_t cond_out_out, // Last conditions written
  output logic cond_out_stb_out, // Conditions written pulse
  output iob_pkg::iob_word_t data_out_out, // Last data written
  output logic data_out_stb_out, // Data written pulse
  output logic served_out // Selected for service pulse
);
  import iob_pkg::*;
  logic dem_q;
  logic sel_io;
  logic sel_phys;
  logic sel_srv;
  logic srv_seen;
  logic dem_rise;
  // Decode of select and function lines while demand stands
  assign sel_io = bus.demand && (bus.cs == SELECT_CODE) && !bus.fn[2];
  assign sel_phys = bus.demand && (bus.fn == IOB_FN_SERVED)
                    && (bus.cs[2:0] == CHANNEL) && int_req_in;
  assign sel_srv = bus.demand && (bus.fn == IOB_FN_VECTOR)
                   && (bus.cs[6:3] == PHYS_NUM) && int_req_in;
  assign dem_rise = bus.demand && !dem_q;
  assign bus.int_req = (8'h80 >> CHANNEL) & {8{int_req_in}};
  // Responses are registered so transfer, acknowledge and data outputs come from flip-flops; int_req is combinational
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      dem_q <= 1'b0;
      bus.transfer_strobe <= 1'b0;
      bus.ack <= 1'b0;
      bus.ctl_data_oe <= 1'b0;
      bus.ctl_data <= '0;
    end else begin
      dem_q <= bus.demand;
      bus.transfer_strobe <= sel_io || sel_srv;
      bus.ack <= sel_io || sel_phys || sel_srv;
      bus.ctl_data_oe <= (sel_io && bus.fn[0]) || sel_phys || sel_srv;
      if (sel_srv) begin
        bus.ctl_data <= vector_in;
      end else if (sel_phys) begin
        bus.ctl_data <= '0;
        bus.ctl_data[PHYS_NUM] <= 1'b1;
      end else if (bus.fn == IOB_FN_CONDITIONS_IN) begin
        bus.ctl_data <= cond_in_in;
      end else begin
        bus.ctl_data <= data_in_in;
      end
    end
  end
  // Write functions capture once per demand
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cond_out_out <= '0;
      data_out_out <= '0;
      cond_out_stb_out <= 1'b0;
      data_out_stb_out <= 1'b0;
    end else begin
      cond_out_stb_out <= sel_io && dem_rise && (bus.fn == IOB_FN_CONDITIONS_OUT);
      data_out_stb_out <= sel_io && dem_rise && (bus.fn == IOB_FN_DATA_OUT);
      if (sel_io && dem_rise && bus.fn == IOB_FN_CONDITIONS_OUT) begin
        cond_out_out <= bus.data;
      end
      if (sel_io && dem_rise && bus.fn == IOB_FN_DATA_OUT) begin
        data_out_out <= bus.data;
      end
    end
  end
  // Service is reported once, after demand is down and the function lines leave the vector code
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      srv_seen <= 1'b0;
      served_out <= 1'b0;
    end else begin
      served_out <= srv_seen && !bus.demand && bus.fn != IOB_FN_VECTOR;
      if (sel_srv) begin
        srv_seen <= 1'b1;
      end else if (served_out) begin
        srv_seen <= 1'b0;
      end
    end
  end
endmodule : iob_ctl
`default_nettype wire

/* logic/iob_proc.sv */
// Processor end of the I/O bus: arbitration, interrupt sampling, timed dialogue
`timescale 1ns/1ps
`default_nettype none
module iob_proc #(
  parameter int T2_CYC = iob_pkg::IOB_TSTATE_CYC, // Per-state durations
  parameter int T3_CYC = iob_pkg::IOB_TSTATE_CYC,
  parameter int T4_CYC = iob_pkg::IOB_TSTATE_CYC,
  parameter int T5_CYC = iob_pkg::IOB_TSTATE_CYC,
  parameter int T6_CYC = iob_pkg::IOB_TSTATE_CYC,
  parameter int T7_CYC = iob_pkg::IOB_TSTATE_CYC,
  parameter int TRANSFER_STROBE_TMO_CYC = iob_pkg::IOB_TRANSFER_STROBE_TMO_CYC
) (
  input wire logic sys_clk_in, // System clock
  input wire logic rst_in, // Async reset, active high
  iob_bus_if.proc bus, // I/O bus
  input wire logic eu_req_in, // Execution unit wants bus, level
  input wire logic bus_return_demand_in, // Page fault forces bus back
  input wire logic [6:0] eu_cs_in, // Execution unit select code
  input wire logic [2:0] eu_fn_in, // Execution unit function
  input wire logic eu_demand_in, // Execution unit demand
  input wire iob_pkg::iob_word_t eu_data_in, // Execution unit write data
  output logic eu_grant_out, // Execution unit owns bus
  output iob_pkg::iob_word_t eu_rdata_out, // Data sampled from bus
  input wire logic intsys_on_in, // Interrupt system on
  input wire logic conditions_out_we_in, // Conditions-out write to interrupt system
  input wire logic [1:7] conditions_out_enable_in, // New channel enables
  output logic [1:7] channel_enable_out, // Current channel enables
  input wire logic interrupt_cycle_flag_in, // Microprogram interrupt cycle
  output logic interrupt_bus_grant_out, // Interrupt system owns bus
  output logic translator_inbound_dir_out, // Data received, not driven
  output logic [2:0] served_channel_out, // Channel being served
  output logic [3:0] served_phys_out, // Controller chosen
  output iob_pkg::iob_word_t vector_word_out, // Captured special word
  output logic vector_valid_out // Word captured pulse
);
  import iob_pkg::*;
  iob_owner_t owner;
  iob_ring_t ring;
  iob_tstate_t ts;
  logic [IOB_CNT_W-1:0] cnt;
  logic [IOB_CNT_W-1:0] tmo;
  logic [0:7] req_reg;
  logic [0:7] qual_req;
  logic [2:0] chan;
  logic interrupt_test;
  logic interrupt_bus_request;
  logic interrupt_timer_start;
  logic flag_seen;
  logic transfer_strobe_seen;
  logic tdone;
  logic adv;
  logic pi_own;
  logic abort;
  iob_tstate_t next_ts;

  // Load count for each time state
  function automatic logic [IOB_CNT_W-1:0] state_cnt(input iob_tstate_t s);
    logic [IOB_CNT_W-1:0] r;
    case (s)
      IOB_TS_T2: r = IOB_CNT_W'(T2_CYC - 1);
      IOB_TS_T3: r = IOB_CNT_W'(T3_CYC - 1);
      IOB_TS_T4: r = IOB_CNT_W'(T4_CYC - 1);
      IOB_TS_T5: r = IOB_CNT_W'(T5_CYC - 1);
      IOB_TS_T6: r = IOB_CNT_W'(T6_CYC - 1);
      IOB_TS_T7: r = IOB_CNT_W'(T7_CYC - 1);
      default: r = IOB_CNT_RST;
    endcase
    return r;
  endfunction : state_cnt

  //==============================================================
  // Request sampling and priority
  //==============================================================
  // Channel 0 is never gated, the rest need system on and enable
  always_comb begin
    qual_req[0] = bus.int_req[0];
    for (int i = 1; i < IOB_CHANS; i++) begin
      qual_req[i] = bus.int_req[i] && intsys_on_in && channel_enable_out[i];
    end
  end

  // Enables are software state; only a conditions-out write changes them
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      channel_enable_out <= '0;
    end else if (conditions_out_we_in) begin
      channel_enable_out <= conditions_out_enable_in;
    end
  end

  assign interrupt_bus_request = (ring == IOB_RC_TEST);
  assign interrupt_test = interrupt_bus_request;
  assign abort = pi_own && bus_return_demand_in;

  // Ring counter: load, two waits, test, then frozen during dialogue
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ring <= IOB_RC_LOAD;
      req_reg <= '0;
      chan <= 3'h0;
      flag_seen <= 1'b0;
    end else begin
      case (ring)
        IOB_RC_LOAD: begin
          req_reg <= qual_req;
          flag_seen <= 1'b0;
          if (|qual_req) begin
            ring <= IOB_RC_WAIT1;
          end
        end
        IOB_RC_WAIT1: begin
          chan <= 3'(iob_lowest({req_reg, 8'h00}));
          ring <= IOB_RC_WAIT2;
        end
        IOB_RC_WAIT2: begin
          chan <= 3'(iob_lowest({req_reg, 8'h00}));
          ring <= IOB_RC_TEST;
        end
        IOB_RC_TEST: begin
          if (owner == IOB_OWN_INT) begin
            ring <= IOB_RC_FROZEN;
          end
        end
        IOB_RC_FROZEN: begin
          if (interrupt_cycle_flag_in) begin
            flag_seen <= 1'b1;
          end
          if (abort || (flag_seen && !interrupt_cycle_flag_in)) begin
            ring <= IOB_RC_LOAD;
          end
        end
        default: ring <= IOB_RC_LOAD;
      endcase
    end
  end

  //==============================================================
  // Bus arbitration
  //==============================================================
  // First come first served; a same-cycle tie goes to the execution unit
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      owner <= IOB_OWN_NONE;
    end else begin
      case (owner)
        IOB_OWN_NONE: begin
          if (eu_req_in) begin
            owner <= IOB_OWN_EU;
          end else if (interrupt_bus_request) begin
            owner <= IOB_OWN_INT;
          end
        end
        IOB_OWN_EU: begin
          if (!eu_req_in) begin
            owner <= IOB_OWN_NONE;
          end
        end
        IOB_OWN_INT: begin
          if (abort) begin
            owner <= IOB_OWN_EU;
          end else if (ts == IOB_TS_COMP) begin
            owner <= IOB_OWN_NONE;
          end
        end
        default: owner <= IOB_OWN_NONE;
      endcase
    end
  end

  assign pi_own = (owner == IOB_OWN_INT);
  assign eu_grant_out = (owner == IOB_OWN_EU);
  assign interrupt_bus_grant_out = pi_own;
  assign translator_inbound_dir_out = pi_own;
  assign interrupt_timer_start = interrupt_bus_request && !eu_req_in
                                 && (owner == IOB_OWN_NONE);

  //==============================================================
  // Interrupt timer and time-state generator
  //==============================================================
  assign tdone = (cnt == IOB_CNT_RST);
  // Advance only when the count runs out and no interlock holds
  assign adv = tdone && !(ts == IOB_TS_T6 && !interrupt_cycle_flag_in);

  always_comb begin
    case (ts)
      IOB_TS_T2: next_ts = IOB_TS_T3;
      IOB_TS_T3: next_ts = IOB_TS_T4;
      IOB_TS_T4: next_ts = IOB_TS_T5;
      IOB_TS_T5: next_ts = IOB_TS_T6;
      IOB_TS_T6: next_ts = IOB_TS_T7;
      IOB_TS_T7: next_ts = IOB_TS_COMP;
      default: next_ts = IOB_TS_IDLE;
    endcase
  end

  // The transfer wait is forced after a timeout so a silent bus cannot hang us
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ts <= IOB_TS_IDLE;
      cnt <= IOB_CNT_RST;
      tmo <= IOB_CNT_RST;
      transfer_strobe_seen <= 1'b0;
    end else if (abort) begin
      ts <= IOB_TS_IDLE;
      cnt <= IOB_CNT_RST;
    end else if (interrupt_timer_start) begin
      ts <= IOB_TS_T2;
      cnt <= state_cnt(IOB_TS_T2);
      transfer_strobe_seen <= 1'b0;
      tmo <= IOB_CNT_RST;
    end else if (ts == IOB_TS_T5 && !transfer_strobe_seen) begin
      tmo <= tmo + 8'h01;
      transfer_strobe_seen <= bus.transfer_strobe || (tmo == IOB_CNT_W'(TRANSFER_STROBE_TMO_CYC - 1));
    end else if (ts == IOB_TS_COMP) begin
      ts <= IOB_TS_IDLE;
    end else if (ts != IOB_TS_IDLE) begin
      if (!tdone) begin
        cnt <= cnt - 8'h01;
      end else if (adv) begin
        ts <= next_ts;
        cnt <= state_cnt(next_ts);
      end else begin
        cnt <= state_cnt(IOB_TS_T6);
      end
    end
  end

  //==============================================================
  // Bus drive and capture
  //==============================================================
  // Demand lives only in T2, T5, T6 so it is gone before lines release
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      bus.cs <= 7'h00;
      bus.fn <= 3'h0;
      bus.demand <= 1'b0;
      bus.proc_data <= '0;
      bus.proc_data_oe <= 1'b0;
      served_channel_out <= 3'h0;
      served_phys_out <= 4'h0;
    end else if (owner == IOB_OWN_EU) begin
      bus.cs <= eu_cs_in;
      bus.fn <= eu_fn_in;
      bus.demand <= eu_demand_in;
      bus.proc_data <= eu_data_in;
      bus.proc_data_oe <= !eu_fn_in[0] && !eu_fn_in[2];
    end else if (pi_own && !abort && ts != IOB_TS_COMP) begin
      bus.proc_data_oe <= 1'b0;
      bus.demand <= (ts == IOB_TS_T2) || (ts == IOB_TS_T5)
                    || (ts == IOB_TS_T6);
      if (ts == IOB_TS_T2 && cnt == state_cnt(IOB_TS_T2)) begin
        bus.cs[2:0] <= chan;
        bus.fn <= IOB_FN_SERVED;
        served_channel_out <= chan;
      end
      // Controllers answer a cycle after demand, so numbers are taken on entering T3
      if (ts == IOB_TS_T3 && cnt == state_cnt(IOB_TS_T3)) begin
        served_phys_out <= iob_lowest(bus.data[0:15]);
        bus.cs[6:3] <= iob_lowest(bus.data[0:15]);
      end
      if (ts == IOB_TS_T3 && adv) begin
        bus.fn[0] <= 1'b1;
      end
    end else begin
      bus.cs <= 7'h00;
      bus.fn <= 3'h0;
      bus.demand <= 1'b0;
      bus.proc_data_oe <= 1'b0;
    end
  end

  // Special word is taken at the end of T5 once it has settled
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      vector_word_out <= '0;
      vector_valid_out <= 1'b0;
      eu_rdata_out <= '0;
    end else begin
      eu_rdata_out <= bus.data;
      vector_valid_out <= (ts == IOB_TS_T5) && transfer_strobe_seen && tdone;
      if ((ts == IOB_TS_T5) && transfer_strobe_seen && tdone) begin
        vector_word_out <= bus.data;
      end
    end
  end
endmodule : iob_proc
`default_nettype wire

/* verification/iob_assertions.sv */
// Concurrent checks on the I/O bus joining the processor and controller ends
`timescale 1ns/1ps
`default_nettype none
module iob_assertions #(
  parameter logic [6:0] SELECT_CODE = 7'h01,
  parameter logic [3:0] PHYS_NUM = 4'h1,
  parameter logic [2:0] CHANNEL = 3'h1
) (
  input wire logic sys_clk_in, // System clock
  input wire logic rst_in, // Async reset, active high
  input wire logic [6:0] cs, // Select lines
  input wire logic [2:0] fn, // Function lines
  input wire logic demand, // Demand line
  input wire logic ack, // Acknowledge line
  input wire logic transfer_strobe, // Transfer line
  input wire logic eu_grant_out, // Execution unit owns bus
  input wire logic interrupt_bus_grant_out, // Interrupt system owns bus
  input wire logic translator_inbound_dir_out, // Inbound data direction
  input wire logic bus_return_demand_in, // Bus forced back
  input wire logic interrupt_cycle_flag_in // Microprogram interrupt cycle
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // ==========================================================
  // Steps of the dialogue
  // A forced return drops everything at once, so it is kept out of the ordering checks
  sequence s_ctl_selected;
    demand && !fn[2] && cs == SELECT_CODE;
  endsequence
  sequence s_lines_drop;
    $fell(fn[2]) && !$past(bus_return_demand_in);
  endsequence
  sequence s_grant_end;
    $fell(interrupt_bus_grant_out) && !$past(bus_return_demand_in);
  endsequence
  // ==========================================================
  // Assertions
  AST_GRANT_INBOUND: assert property (interrupt_bus_grant_out |-> translator_inbound_dir_out)
    else $error("inbound direction missing under interrupt grant");
  AST_FN_HIGH: assert property ($rose(demand) && interrupt_bus_grant_out |-> fn[2])
    else $error("function high bit missing at interrupt demand");
  AST_CHAN_LOW: assert property (demand && fn == 3'h4 |-> cs[2:0] == CHANNEL)
    else $error("low select lines do not carry the served channel");
  AST_PHYS_HIGH: assert property (demand && fn == 3'h5 |-> cs[6:3] == PHYS_NUM)
    else $error("high select lines do not carry the chosen controller");
  AST_DEMAND_FIRST: assert property (s_lines_drop |-> !$past(demand))
    else $error("function lines removed while demand still up");
  AST_CTL_ANSWER: assert property (s_ctl_selected |=> transfer_strobe && ack)
    else $error("selected controller did not answer demand");
  AST_SILENT: assert property (demand && !fn[2] && cs != SELECT_CODE |=> !transfer_strobe && !ack)
    else $error("controller answered a foreign select code");
  AST_TRANSFER_STROBE_DEMAND: assert property (!demand |=> !transfer_strobe)
    else $error("transfer without demand");
  AST_EXCL: assert property (!(eu_grant_out && interrupt_bus_grant_out))
    else $error("bus granted to both owners");
  AST_RETURN: assert property (bus_return_demand_in && interrupt_bus_grant_out |-> ##[1:4] !interrupt_bus_grant_out)
    else $error("return demand did not take the bus back");
  AST_T6_HOLD: assert property (s_grant_end |-> $past(interrupt_cycle_flag_in))
    else $error("dialogue completed without interrupt cycle flag");
endmodule : iob_assertions
`default_nettype wire

/* verification/tb_top.sv */
// Self-checking bench for the processor and controller ends of the I/O bus
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  import iob_pkg::*;
  localparam logic [6:0] SEL = 7'h15;
  localparam logic [3:0] PHYS = 4'h9;
  localparam logic [2:0] CHAN = 3'h2;
  localparam iob_word_t VEC = 36'h5_a5a5_a5a5;
  localparam iob_word_t CIN = 36'h0_00c0_ffee;
  localparam iob_word_t DIN = 36'hf_0000_1234;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic eu_req = 1'b0, ret_dem = 1'b0, eu_dem = 1'b0, intsys_on = 1'b1;
  logic conditions_out_we = 1'b0, flag = 1'b0, int_req_in = 1'b0, served_seen = 1'b0;
  logic [6:0] eu_cs = 7'h00;
  logic [2:0] eu_fn = 3'h0;
  logic [1:7] conditions_out_en = 7'h00;
  iob_word_t eu_data = '0;
  iob_word_t rdata, vec_word, cond_out, data_out;
  logic eu_grant, int_grant, inbound, vec_valid, served;
  logic [1:7] chan_en;
  logic [2:0] srv_chan;
  logic [3:0] srv_phys;
  logic conditions_out_stb, data_out_stb;
  int conditions_out_n = 0;
  int data_out_n = 0;
  int err_count = 0;
  int total_checks = 0;
  iob_bus_if bus ();
  // ==========================================================
  // Both ends and the checker
  iob_proc #(.T2_CYC(2), .T3_CYC(2), .T4_CYC(2), .T5_CYC(2), .T6_CYC(2), .T7_CYC(2),
    .TRANSFER_STROBE_TMO_CYC(8)) iob_proc_inst (
    .sys_clk_in(clk), .rst_in(rst), .bus(bus), .eu_req_in(eu_req),
    .bus_return_demand_in(ret_dem), .eu_cs_in(eu_cs), .eu_fn_in(eu_fn),
    .eu_demand_in(eu_dem), .eu_data_in(eu_data), .eu_grant_out(eu_grant),
    .eu_rdata_out(rdata), .intsys_on_in(intsys_on), .conditions_out_we_in(conditions_out_we),
    .conditions_out_enable_in(conditions_out_en), .channel_enable_out(chan_en), .interrupt_cycle_flag_in(flag),
    .interrupt_bus_grant_out(int_grant), .translator_inbound_dir_out(inbound),
    .served_channel_out(srv_chan), .served_phys_out(srv_phys),
    .vector_word_out(vec_word), .vector_valid_out(vec_valid));
  iob_ctl #(.SELECT_CODE(SEL), .PHYS_NUM(PHYS), .CHANNEL(CHAN)) iob_ctl_inst (
    .sys_clk_in(clk), .rst_in(rst), .bus(bus), .int_req_in(int_req_in), .vector_in(VEC),
    .cond_in_in(CIN), .data_in_in(DIN), .cond_out_out(cond_out), .cond_out_stb_out(conditions_out_stb),
    .data_out_out(data_out), .data_out_stb_out(data_out_stb), .served_out(served));
  iob_assertions #(.SELECT_CODE(SEL), .PHYS_NUM(PHYS), .CHANNEL(CHAN)) iob_assertions_inst (
    .sys_clk_in(clk), .rst_in(rst), .cs(bus.cs), .fn(bus.fn), .demand(bus.demand),
    .ack(bus.ack), .transfer_strobe(bus.transfer_strobe), .eu_grant_out(eu_grant),
    .interrupt_bus_grant_out(int_grant), .translator_inbound_dir_out(inbound),
    .bus_return_demand_in(ret_dem), .interrupt_cycle_flag_in(flag));
  // Clock, and notes of the two-cycle service pulse and the one-cycle write pulses
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (served === 1'b1) begin
      served_seen <= 1'b1;
    end
    if (conditions_out_stb === 1'b1) begin
      conditions_out_n <= conditions_out_n + 1;
    end
    if (data_out_stb === 1'b1) begin
      data_out_n <= data_out_n + 1;
    end
  end
  // ==========================================================
  // Helpers
  function automatic logic pick(input int s);
    case (s)
      0: return eu_grant;
      1: return bus.transfer_strobe;
      2: return int_grant;
      3: return vec_valid;
      default: return !int_grant;
    endcase
  endfunction : pick
  // Bounded wait; a line that never comes is caught by the check that follows
  task automatic wait_on(input int s, input int lim);
    int n;
    n = 0;
    while (pick(s) !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_on
  // One execution unit transfer; demand drops before select and function lines
  task automatic eu_op(input logic [6:0] cs, input logic [2:0] fn, input iob_word_t w,
                       input logic hit, input iob_word_t exp);
    iob_word_t got;
    @(posedge clk);
    eu_req <= 1'b1;
    wait_on(0, 20);
    eu_cs <= cs;
    eu_fn <= fn;
    eu_data <= w;
    eu_dem <= 1'b1;
    wait_on(1, 12);
    `CHK("transfer_strobe", hit, bus.transfer_strobe)
    repeat (2) @(posedge clk);
    got = (fn == 3'h0) ? cond_out : (fn == 3'h2) ? data_out : rdata;
    `CHK("eu_word", exp, got)
    eu_dem <= 1'b0;
    repeat (2) @(posedge clk);
    eu_req <= 1'b0;
    eu_cs <= 7'h00;
    eu_fn <= 3'h0;
    @(posedge clk);
  endtask : eu_op
  task automatic end_test(input string nm);
    $display("test %s done: checks %0d bad %0d", nm, total_checks, err_count);
  endtask : end_test
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run
  // ==========================================================
  // Tests
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    // Every data function code, then a select code nobody is wired to
    eu_op(SEL, 3'h0, 36'h1_2345_6789, 1'b1, 36'h1_2345_6789);
    eu_op(SEL, 3'h1, '0, 1'b1, CIN);
    eu_op(SEL, 3'h2, 36'h8_0000_0001, 1'b1, 36'h8_0000_0001);
    eu_op(SEL, 3'h3, '0, 1'b1, DIN);
    `CHK("msb", 1'b1, data_out[0])
    eu_op(7'h16, 3'h2, 36'h7_7777_7777, 1'b0, 36'h8_0000_0001);
    `CHK("conditions_out_stb", 1, conditions_out_n)
    `CHK("data_out_stb", 1, data_out_n)
    end_test("data");
    // Request on a channel whose enable is still clear is ignored
    int_req_in <= 1'b1;
    wait_on(2, 40);
    `CHK("masked", 1'b0, int_grant)
    conditions_out_en <= 7'b0100000;
    intsys_on <= 1'b0;
    conditions_out_we <= 1'b1;
    @(posedge clk);
    conditions_out_we <= 1'b0;
    wait_on(2, 40);
    `CHK("sys_off", 1'b0, int_grant)
    intsys_on <= 1'b1;
    wait_on(2, 40);
    `CHK("grant", 1'b1, int_grant)
    `CHK("enables", 7'b0100000, chan_en)
    `CHK("inbound", 1'b1, inbound)
    wait_on(3, 80);
    `CHK("vector", VEC, vec_word)
    `CHK("phys", PHYS, srv_phys)
    `CHK("channel", CHAN, srv_chan)
    // The dialogue must sit in T6 until the flag arrives
    repeat (30) @(posedge clk);
    `CHK("t6_hold", 1'b1, int_grant)
    flag <= 1'b1;
    wait_on(4, 30);
    `CHK("released", 1'b0, int_grant)
    repeat (3) @(posedge clk);
    `CHK("served", 1'b1, served_seen)
    int_req_in <= 1'b0;
    repeat (4) @(posedge clk);
    flag <= 1'b0;
    repeat (10) @(posedge clk);
    end_test("interrupt");
    // Execution unit holds the bus, then takes it back from the interrupt system
    eu_req <= 1'b1;
    wait_on(0, 20);
    int_req_in <= 1'b1;
    repeat (30) @(posedge clk);
    `CHK("eu_holds", 1'b0, int_grant)
    eu_req <= 1'b0;
    wait_on(2, 40);
    `CHK("int_after", 1'b1, int_grant)
    eu_req <= 1'b1;
    ret_dem <= 1'b1;
    int_req_in <= 1'b0;
    wait_on(0, 10);
    `CHK("returned", 1'b1, eu_grant)
    `CHK("int_off", 1'b0, int_grant)
    repeat (4) @(posedge clk);
    ret_dem <= 1'b0;
    eu_req <= 1'b0;
    repeat (10) @(posedge clk);
    end_test("arbitration");
    complete_run();
  end
  // Watchdog: the tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
